// ### design/vid_softstart_sequencer.sv
// Purpose: voltage-code tracking, enable/shutdown decision and soft-start ramp sequencing
// Assumes: comparator results arrive as async levels; arst_n_i is the supply-ok reset
// Notes: one switching cycle is six sample slots of the core clock
//
// What this block does
// - sample code six times per switching cycle
// - changed code: wait half cycle, step 12.5mV
// - sign reversal during wait cancels the step
// - far code: step every slot until one step away
// - shutdown holds phase outputs high impedance
// - all enables true with a non-no-load code and no overvoltage latch starts soft-start immediately
// - logic enable low forces shutdown
// - no-load codes shut down, others restart
// - no-load: two cycles, then trip level, disable
// - code changes never clear overvoltage shutdown
// - soft-start ramps reference from zero linearly
// - phases stay high impedance until ramp reaches output or soft-start ends
// - soft-start opens with 64-cycle delay
// - ramp takes 1280 cycles per volt
// - 100mV sense offset falls to zero over 640 cycles
// - 25mV steps first 640 cycles, then 12.5mV
// - output ok after soft-start within window
// - decode six-bit code into reference level
`timescale 1ns/10ps
module vid_softstart_sequencer
  import softstart_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] voltage_id_code_i,
  input wire logic half_step_id_bit_i,
  input wire logic threshold_enable_i,
  input wire logic logic_enable_i,
  input wire logic ov_latched_i,
  input wire logic ref_reached_output_i,
  input wire logic output_in_window_i,
  output seq_status_t status_o
);

  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  logic [5:0] slot_cnt_r;
  logic [2:0] slot_idx_r;
  seq_state_t state_r, state_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic [3:0] ofs_r, ofs_nxt;
  logic hiz_r, hiz_nxt;
  logic ovl_r, ovl_nxt;
  logic ok_r, ok_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [6:0] div_r, div_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic wup_r, wup_nxt;
  logic [5:0] last_code_r, last_code_nxt;

  // every pin comparator is asynchronous to the core clock
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {voltage_id_code_i, half_step_id_bit_i, threshold_enable_i,
                     logic_enable_i, ov_latched_i, ref_reached_output_i,
                     output_in_window_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire [5:0] code_s = pin_sync_r[10:5];
  wire thr_s = pin_sync_r[4];
  wire len_s = pin_sync_r[3];
  wire ov_s = pin_sync_r[2];
  wire reached_s = pin_sync_r[1];
  wire window_s = pin_sync_r[0];

  wire slot_tick = (slot_cnt_r == SLOT_LAST);
  wire sw_tick = slot_tick && (slot_idx_r == SLOT_IDX_LAST);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot_cnt_r <= '0;
      slot_idx_r <= '0;
    end else begin
      slot_cnt_r <= slot_tick ? 6'h00 : slot_cnt_r + 6'h01;
      if (slot_tick)
        slot_idx_r <= sw_tick ? 3'h0 : slot_idx_r + 3'h1;
    end
  end

  wire [7:0] tgt_units = code_to_units(code_s);
  wire noload = is_noload(code_s);
  wire last_noload = is_noload(last_code_r);
  // overvoltage latch is held outside; only its release can restart us
  wire kill = !thr_s || !len_s || ov_s;
  wire start_ok = thr_s && len_s && !noload && !ov_s;
  wire up = tgt_units > ref_r;
  wire dn = tgt_units < ref_r;
  wire [7:0] gap = up ? tgt_units - ref_r : ref_r - tgt_units;
  wire far = gap > FINE_STEP;
  wire code_chg = slot_tick && (code_s != last_code_r);
  wire [7:0] ref_step = up ? ref_r + FINE_STEP : (dn ? ref_r - FINE_STEP : ref_r);
  wire coarse_phase = cnt_r < COARSE_END;
  wire coarse_due = sw_tick && (cnt_r[4:0] == COARSE_MASK);
  wire fine_due = sw_tick && (cnt_r[3:0] == FINE_MASK);

  // ramp toward target, clamped so an odd target is never overshot
  function automatic logic [7:0] ramp_add(input logic [7:0] cur,
                                          input logic [7:0] tgt,
                                          input logic [7:0] step);
    logic [8:0] sum;
    sum = {1'b0, cur} + {1'b0, step};
    if (sum >= {1'b0, tgt})
      return tgt;
    else
      return sum[7:0];
  endfunction

  always_comb begin
    state_nxt = state_r;
    ref_nxt = ref_r;
    ofs_nxt = ofs_r;
    hiz_nxt = hiz_r;
    ovl_nxt = ovl_r;
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    wait_nxt = wait_r;
    wup_nxt = wup_r;
    last_code_nxt = slot_tick ? code_s : last_code_r;
    unique case (state_r)
      ST_OFF: begin
        hiz_nxt = 1'b1;
        if (start_ok) begin
          state_nxt = ST_DELAY;
          ref_nxt = 8'h00;
          ofs_nxt = OFFSET_UNITS;
          cnt_nxt = '0;
          div_nxt = '0;
          ovl_nxt = 1'b0;
        end
      end
      ST_DELAY: begin
        if (sw_tick) begin
          if (cnt_r == DELAY_LAST) begin
            state_nxt = ST_RAMP;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
      end
      ST_RAMP: begin
        if (reached_s)
          hiz_nxt = 1'b0;
        if (sw_tick && cnt_r != '1)
          cnt_nxt = cnt_r + 12'h001;
        if (coarse_phase) begin
          if (coarse_due)
            ref_nxt = ramp_add(ref_r, tgt_units, COARSE_STEP);
          if (sw_tick) begin
            div_nxt = (div_r == OFS_DIV_LAST) ? 7'h00 : div_r + 7'h01;
            if (div_r == OFS_DIV_LAST && ofs_r != 4'h0)
              ofs_nxt = ofs_r - 4'h1;
          end
        end else begin
          ofs_nxt = 4'h0;
          if (fine_due)
            ref_nxt = ramp_add(ref_r, tgt_units, FINE_STEP);
        end
        if (ref_r >= tgt_units && !coarse_phase) begin
          state_nxt = ST_RUN;
          hiz_nxt = 1'b0;
          wait_nxt = '0;
        end
      end
      ST_RUN: begin
        hiz_nxt = 1'b0;
        if (code_chg && !last_noload) begin
          wait_nxt = HALF_WAIT_SLOTS;
          wup_nxt = up;
        end else if (slot_tick && wait_r != 2'h0) begin
          if (up != wup_r) begin
            wait_nxt = 2'h0;
          end else begin
            wait_nxt = wait_r - 2'h1;
            if (wait_r == 2'h1)
              ref_nxt = ref_step;
          end
        end else if (slot_tick && far) begin
          // a multi-step jump is chased at six steps per cycle
          ref_nxt = ref_step;
        end
      end
      ST_NOLOAD: begin
        if (sw_tick) begin
          if (cnt_r == NOLOAD_LAST) begin
            state_nxt = ST_OFF;
            ovl_nxt = 1'b1;
            hiz_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
      end
      default: begin
        state_nxt = ST_OFF;
        hiz_nxt = 1'b1;
      end
    endcase
    if (state_r != ST_OFF && kill) begin
      state_nxt = ST_OFF;
      hiz_nxt = 1'b1;
    end else if (state_r != ST_OFF && state_r != ST_NOLOAD && noload) begin
      // phase outputs hold their state (hiz_r) through the two-cycle grace period
      state_nxt = ST_NOLOAD;
      cnt_nxt = '0;
    end
  end

  // flag drops on leaving run or leaving the window, returns with it
  assign ok_nxt = (state_r == ST_RUN) && window_s;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_OFF;
      ref_r <= '0;
      ofs_r <= '0;
      hiz_r <= 1'b1;
      ovl_r <= 1'b0;
      ok_r <= 1'b0;
      cnt_r <= '0;
      div_r <= '0;
      wait_r <= '0;
      wup_r <= 1'b0;
      last_code_r <= '0;
    end else begin
      state_r <= state_nxt;
      ref_r <= ref_nxt;
      ofs_r <= ofs_nxt;
      hiz_r <= hiz_nxt;
      ovl_r <= ovl_nxt;
      ok_r <= ok_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      wait_r <= wait_nxt;
      wup_r <= wup_nxt;
      last_code_r <= last_code_nxt;
    end
  end

  assign status_o.ref_level = ref_r;
  assign status_o.sense_offset = ofs_r;
  assign status_o.phase_hiz = hiz_r;
  assign status_o.ov_shutdown_level = ovl_r;
  assign status_o.output_ok_flag = ok_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_hiz_in_shutdown: assert property (
    (state_r == ST_OFF) |-> status_o.phase_hiz)
    else $error("phase outputs driven in shutdown");

  a_start_now: assert property (
    (state_r == ST_OFF && start_ok) |=> (state_r == ST_DELAY && ref_r == 8'h00))
    else $error("soft-start not begun when enabled");

  a_enable_low_off: assert property (
    (!len_s || !thr_s) |=> (state_r == ST_OFF))
    else $error("enable low but not in shutdown");

  a_ov_blocks: assert property (
    ov_s |=> (state_r == ST_OFF) ##1 (state_r == ST_OFF || !$past(ov_s)))
    else $error("soft-start while overvoltage latched");

  a_noload_enter: assert property (
    (state_r == ST_RUN && noload && !kill) |=> (state_r == ST_NOLOAD))
    else $error("no-load code ignored");

  a_noload_level: assert property (
    $rose(ovl_r) |-> ($past(state_r) == ST_NOLOAD && $past(sw_tick) && hiz_r))
    else $error("shutdown trip level set outside no-load delay");

  a_delay_flat: assert property (
    (state_r == ST_DELAY) |-> (ref_r == 8'h00 && hiz_r))
    else $error("reference moved during start delay");

  a_coarse_hold: assert property (
    (state_r == ST_RAMP && coarse_phase && !coarse_due) |=> $stable(ref_r))
    else $error("coarse ramp stepped off its pacing");

  a_offset_gone: assert property (
    (state_r == ST_RUN) |-> (ofs_r == 4'h0))
    else $error("sense offset left after soft-start");

  a_single_step: assert property (
    (state_r == ST_RUN && $past(state_r) == ST_RUN)
      |-> (ref_r == $past(ref_r) || ref_r == $past(ref_r) + FINE_STEP
           || ref_r == $past(ref_r) - FINE_STEP))
    else $error("code tracking moved more than one step");

  a_wait_half: assert property (
    (state_r == ST_RUN && code_chg && !last_noload && !kill && !noload)
      |=> (wait_r == HALF_WAIT_SLOTS) ##1 $stable(ref_r)[*3])
    else $error("step taken before half-cycle wait");

  a_ok_after_run: assert property (
    status_o.output_ok_flag |-> ($past(state_r) == ST_RUN && $past(window_s)))
    else $error("output ok flag without completed soft-start");

  a_hiz_until_reach: assert property (
    (state_r == ST_RAMP && coarse_phase && hiz_r && !reached_s) |=> hiz_r)
    else $error("phase outputs released before ramp reached output");

  a_offset_fall: assert property (
    (state_r == ST_RAMP && $past(state_r) == ST_RAMP)
      |-> (ofs_r == $past(ofs_r) || ofs_r == $past(ofs_r) - 4'h1))
    else $error("sense offset moved other than down by one unit");

  a_delay_paced: assert property (
    (state_r == ST_DELAY && !sw_tick && !kill && !noload) |=> (state_r == ST_DELAY))
    else $error("start delay left off a switching-cycle tick");

  a_fine_hold: assert property (
    (state_r == ST_RAMP && !coarse_phase && !fine_due) |=> $stable(ref_r))
    else $error("fine ramp stepped off its pacing");

  a_trip_held: assert property (
    (ovl_r && state_r == ST_OFF && !start_ok) |=> ovl_r)
    else $error("shutdown trip level cleared without a restart");

  a_ok_no_offset: assert property (
    status_o.output_ok_flag |-> (status_o.sense_offset == 4'h0))
    else $error("output ok flag raised with sense offset still applied");

  c_reach_run: cover property ((state_r == ST_RAMP) ##1 (state_r == ST_RUN));
  c_noload_off: cover property ((state_r == ST_NOLOAD) ##1 (state_r == ST_OFF));
  c_step_cancel: cover property ((wait_r == 2'h2) ##1 (wait_r == 2'h0));
  c_far_step: cover property (state_r == ST_RUN && slot_tick && far && wait_r == 2'h0);

endmodule

// ### pkg/softstart_pkg.sv
// Purpose: shared constants, types and decode helpers of the soft-start sequencer
// Assumes: reference level counted in 12.5 mV units, switching cycle built from six slots
// Notes: code bit 0 is the half-step bit, bits 5:1 the five main code bits
package softstart_pkg;

  localparam int CLK_FREQ_KHZ = 125000;
  localparam int SW_FREQ_KHZ = 500;
  localparam int SAMPLES_PER_SW = 6;
  // one slot per code sample; the switching cycle is six whole slots
  localparam int SLOT_CYCLES = CLK_FREQ_KHZ / (SW_FREQ_KHZ * SAMPLES_PER_SW);
  localparam logic [5:0] SLOT_LAST = 6'(SLOT_CYCLES - 1);
  localparam logic [2:0] SLOT_IDX_LAST = 3'(SAMPLES_PER_SW - 1);
  localparam logic [1:0] HALF_WAIT_SLOTS = 2'(SAMPLES_PER_SW / 2);

  localparam int STEP_UV = 12500;
  localparam int COARSE_STEP_UV = 25000;
  localparam int OFFSET_UV = 100000;
  localparam logic [7:0] FINE_STEP = 8'h01;
  localparam logic [7:0] COARSE_STEP = 8'(COARSE_STEP_UV / STEP_UV);
  localparam logic [3:0] OFFSET_UNITS = 4'(OFFSET_UV / STEP_UV);

  localparam int SS_DELAY_CYC = 64;
  localparam int RAMP_CYC_PER_V = 1280;
  localparam int COARSE_RAMP_CYC = 640;
  localparam int CYC_PER_UNIT = RAMP_CYC_PER_V * STEP_UV / 1000000;
  localparam int OFFSET_DEC_CYC = COARSE_RAMP_CYC / (OFFSET_UV / STEP_UV);
  localparam int NOLOAD_CYC = 2;
  localparam logic [11:0] DELAY_LAST = 12'(SS_DELAY_CYC - 1);
  localparam logic [11:0] COARSE_END = 12'(COARSE_RAMP_CYC);
  localparam logic [11:0] NOLOAD_LAST = 12'(NOLOAD_CYC - 1);
  localparam logic [4:0] COARSE_MASK = 5'(CYC_PER_UNIT * 2 - 1);
  localparam logic [3:0] FINE_MASK = 4'(CYC_PER_UNIT - 1);
  localparam logic [6:0] OFS_DIV_LAST = 7'(OFFSET_DEC_CYC - 1);

  localparam logic [5:0] NOLOAD_CODE_A = 6'h3F;
  localparam logic [5:0] NOLOAD_CODE_B = 6'h3E;
  // units each segment would give at code bits 4:0 of zero; the decode subtracts those bits
  localparam logic [7:0] LOW_SEG_BASE = 8'h57;
  localparam logic [7:0] WRAP_SEG_BASE = 8'h95;
  localparam logic [7:0] HIGH_SEG_BASE = 8'h75;
  localparam logic [4:0] WRAP_SEG_START = 5'h15;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_DELAY  = 5'h02,
    ST_RAMP   = 5'h04,
    ST_RUN    = 5'h08,
    ST_NOLOAD = 5'h10
  } seq_state_t;

  typedef struct packed {
    logic [7:0] ref_level;
    logic [3:0] sense_offset;
    logic phase_hiz;
    logic ov_shutdown_level;
    logic output_ok_flag;
  } seq_status_t;

  function automatic logic is_noload(input logic [5:0] code);
    return (code == NOLOAD_CODE_A) || (code == NOLOAD_CODE_B);
  endfunction

  // code to reference level in 12.5 mV units
  function automatic logic [7:0] code_to_units(input logic [5:0] code);
    logic [7:0] n;
    n = {3'h0, code[4:0]};
    if (code[5])
      return HIGH_SEG_BASE - n;
    else if (code[4:0] >= WRAP_SEG_START)
      return WRAP_SEG_BASE - n;
    else
      return LOW_SEG_BASE - n;
  endfunction

endpackage

// ### tb/vid_code_source.sv
// Purpose: processor-side model driving the voltage code pins
// Assumes: pins move just after a rising edge, one code step per pace period
// Notes: jump_i applies the target at once, used under reset and for no-load codes
`timescale 1ns/10ps
module vid_code_source #(
  parameter int PACE_CYC = 16
) (
  input wire logic clk_i,
  input wire logic [5:0] tgt_i,
  input wire logic jump_i,
  output logic [4:0] voltage_id_code_o,
  output logic half_step_id_bit_o
);
  logic [5:0] cur_r = 6'h14;
  int pace_r = 0;
  assign {voltage_id_code_o, half_step_id_bit_o} = cur_r;
  always @(posedge clk_i) begin
    if (jump_i) begin
      cur_r <= tgt_i;
    end else if (pace_r > 0) begin
      pace_r <= pace_r - 1;
    end else if (cur_r != tgt_i) begin
      // inside one code segment a code step is one 12.5 mV step
      cur_r <= (cur_r < tgt_i) ? cur_r + 6'h01 : cur_r - 6'h01;
      pace_r <= PACE_CYC;
    end
  end
endmodule

// ### tb/vid_softstart_sequencer_bench.sv
// Purpose: self-checking bench of the soft-start sequencer
// Assumes: counts are fixed in the design, so only the early ramp fits the run length
// Notes: dynamic code stepping needs a finished ramp and is left to the design assertions
`timescale 1ns/10ps
module vid_softstart_sequencer_bench;
  import softstart_pkg::*;
  localparam int SW = SLOT_CYCLES * SAMPLES_PER_SW;
  typedef struct packed {
    logic thr;
    logic len;
    logic ov;
    logic [5:0] code;
    logic [3:0] ofs;
  } row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic thr = 1'b0;
  logic len = 1'b0;
  logic ov = 1'b0;
  logic reached = 1'b0;
  logic in_win = 1'b1;
  logic [5:0] tgt = 6'h14;
  logic jump = 1'b1;
  logic [4:0] vid;
  logic half;
  seq_status_t st;
  int cyc = 0;
  int err_count = 0;
  int n_checks = 0;
  row_t rows [6] = '{'{1'b0, 1'b1, 1'b0, 6'h14, 4'h0}, '{1'b1, 1'b0, 1'b0, 6'h14, 4'h0},
    '{1'b1, 1'b1, 1'b1, 6'h14, 4'h0}, '{1'b1, 1'b1, 1'b0, 6'h3F, 4'h0},
    '{1'b1, 1'b1, 1'b0, 6'h3E, 4'h0}, '{1'b1, 1'b1, 1'b0, 6'h13, 4'h8}};

  always #4 clk = ~clk;

  vid_code_source src (.clk_i(clk), .tgt_i(tgt), .jump_i(jump), .voltage_id_code_o(vid),
    .half_step_id_bit_o(half));

  vid_softstart_sequencer DUT (.core_clk_i(clk), .arst_n_i(arst_n), .voltage_id_code_i(vid),
    .half_step_id_bit_i(half), .threshold_enable_i(thr), .logic_enable_i(len),
    .ov_latched_i(ov), .ref_reached_output_i(reached), .output_in_window_i(in_win),
    .status_o(st));

  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_time(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  function automatic logic [7:0] field(input int sel);
    case (sel)
      0: return st.ref_level;
      1: return {4'h0, st.sense_offset};
      2: return {7'h0, st.phase_hiz};
      default: return {7'h0, st.ov_shutdown_level};
    endcase
  endfunction

  // polls at falling edges until the field leaves its old value
  task automatic wait_chg(input int sel, input logic [7:0] old, input int lim, output int t);
    t = 0;
    while (t < lim && field(sel) === old) begin
      @(negedge clk);
      t++;
    end
  endtask

  // inputs settle under reset so no stale code is synced after release
  task automatic run_row(input row_t r);
    arst_n = 1'b0;
    jump = 1'b1;
    thr = r.thr;
    len = r.len;
    ov = r.ov;
    tgt = r.code;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk_val("row offset", {4'h0, r.ofs}, field(1));
    chk_val("row hiz", 8'h01, field(2));
    chk_val("row ref", 8'h00, field(0));
  endtask

  initial begin
    int t;
    int el;
    // the first row keeps reset for three more cycles, twelve in all
    repeat (9) @(negedge clk);
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    run_row(rows[3]);
    ov = 1'b1;
    tgt = 6'h13;
    repeat (10) @(negedge clk);
    chk_val("ov latched code change", 8'h00, field(1));
    run_row(rows[0]);
    thr = 1'b1;
    wait_chg(1, 8'h00, 10, t);
    chk_time("start latency", 2, 4, t);
    chk_val("start offset", 8'h08, field(1));
    el = t;
    jump = 1'b0;
    tgt = 6'h14;
    wait_chg(0, 8'h00, 30000, t);
    el += t;
    chk_time("first step time", 95 * SW, 97 * SW + 4, el);
    chk_val("first step", 8'h02, field(0));
    wait_chg(0, 8'h02, 9000, t);
    el += t;
    chk_time("coarse period", 32 * SW, 32 * SW, t);
    chk_val("second step", 8'h04, field(0));
    wait_chg(1, 8'h08, 20000, t);
    el += t;
    chk_time("offset first drop", 143 * SW, 145 * SW + 4, el);
    chk_val("offset drop", 8'h07, field(1));
    wait_chg(1, 8'h07, 21000, t);
    chk_time("offset period", 80 * SW, 80 * SW, t);
    chk_val("hiz during ramp", 8'h01, field(2));
    chk_val("ok during ramp", 8'h00, {7'h0, st.output_ok_flag});
    reached = 1'b1;
    wait_chg(2, 8'h01, 10, t);
    chk_time("hiz release", 2, 5, t);
    jump = 1'b1;
    tgt = 6'h3F;
    wait_chg(3, 8'h00, 700, t);
    chk_time("no-load delay", SW + 2, 2 * SW + 5, t);
    chk_val("no-load hiz", 8'h01, field(2));
    chk_val("no-load ok", 8'h00, {7'h0, st.output_ok_flag});
    // paced walk down passes the other no-load code before a valid one
    jump = 1'b0;
    tgt = 6'h13;
    wait_chg(3, 8'h01, 40, t);
    chk_time("restart latency", 20, 22, t);
    chk_val("restart offset", 8'h08, field(1));
    arst_n = 1'b0;
    @(negedge clk);
    chk_val("reset ref", 8'h00, field(0));
    chk_val("reset hiz", 8'h01, field(2));
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    print_verdict();
  end
endmodule
